// *** hdl/fpl_ctrl.sv ***
// Purpose: Face plate power LED, fault LED and request button controller.
// Assumes: APB slave with one wait-free access phase; fault inputs are pins.
// Notes:   The button only requests state changes; power is never switched.
`timescale 1ns/1ps
`default_nettype none
module fpl_ctrl
    import fpl_pkg::*;
#(
    parameter int SLOW_CYC     = SLOW_PERIOD_CYC,
    parameter int SPACED_CYC   = SPACED_PERIOD_CYC,
    parameter int SPACED_ON    = SPACED_CYC /
                                 (SPACED_PERIOD_CYC / SPACED_ON_CYC),
    parameter int IDENT_BLINK  = IDENT_PERIOD_CYC,
    parameter int IDENT_CYC    = IDENT_DUR_CYC,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic                  button_n,
    input  wire logic [NUM_FAULTS-1:0] fault_in,
    output var  logic                  power_led,
    output var  logic                  fault_led,
    output var  logic                  irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    fpl_ctrl_t             ctrl_q;
    logic [NUM_FAULTS-1:0] fmask_q;
    logic [NUM_FAULTS-1:0] fsync1_q;
    logic [NUM_FAULTS-1:0] fsync2_q;
    logic [NUM_INTS-1:0]   int_stat_q;
    logic [NUM_INTS-1:0]   int_en_q;
    logic [NUM_INTS-1:0]   int_set;
    logic [NUM_INTS-1:0]   int_clr;
    fpl_state_t            state_q;
    fpl_state_t            state_d;
    logic                  policy_q;
    logic                  policy_d;
    fpl_event_t            event_q;
    logic [3:0]            cause_d;
    logic                  state_chg;
    logic                  ident_q;
    logic [31:0]           ident_cnt_q;
    logic                  ident_exp;
    logic                  press_raw;
    logic                  press;
    logic                  slow_blink;
    logic                  spaced_blink;
    logic                  ident_blink;
    logic                  wr_acc;
    logic                  setup;
    logic                  cm_advance;
    logic                  cm_abort;
    logic                  fault_any;

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        read_mux = 32'h0;
        unique case (a)
            ADDR_CTRL:     read_mux = 32'(ctrl_q);
            ADDR_FMASK:    read_mux = 32'(fmask_q);
            ADDR_STATUS:   read_mux = {16'h0, 8'(fsync2_q), ident_q,
                                       policy_q, 6'(state_q)};
            ADDR_EVENT:    read_mux = 32'(event_q);
            ADDR_INT_STAT: read_mux = 32'(int_stat_q);
            ADDR_INT_EN:   read_mux = 32'(int_en_q);
            default:       read_mux = 32'h0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ADDR_INT_EN);
    endfunction

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Read data is captured in the setup cycle so that prdata comes from
    // a flop; the price is a fixed one-cycle access phase.
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite && !pslverr;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else if (setup)
        begin
            pready  <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata  <= pwrite ? 32'h0 : read_mux(paddr);
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= CTRL_RST;
            fmask_q  <= FMASK_RST;
            int_en_q <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == ADDR_CTRL)
                ctrl_q <= fpl_ctrl_t'(pwdata[3:0]);
            if (paddr == ADDR_FMASK)
                fmask_q <= pwdata[NUM_FAULTS-1:0];
            if (paddr == ADDR_INT_EN)
                int_en_q <= pwdata[NUM_INTS-1:0];
        end
    end

    assign cm_advance = wr_acc && (paddr == ADDR_CMD) && pwdata[CMD_ADVANCE];
    assign cm_abort   = wr_acc && (paddr == ADDR_CMD) && pwdata[CMD_ABORT];
    assign int_clr    = (wr_acc && (paddr == ADDR_INT_CLR)) ?
                        pwdata[NUM_INTS-1:0] : '0;

    // ----------------------------------------------------------------
    // Request button
    // ----------------------------------------------------------------
    fpl_debounce #(
        .STABLE_CYC (DEBOUNCE_CYCLES)
    ) u_debounce (
        .pclk     (pclk),
        .presetn  (presetn),
        .button_n (button_n),
        .press    (press_raw)
    );

    assign press = press_raw && ctrl_q.btn_en;

    // ----------------------------------------------------------------
    // Operational state and activation policy
    // ----------------------------------------------------------------
    // A press only moves the state machine; nothing here reaches power.
    always_comb
    begin
        state_d  = state_q;
        policy_d = policy_q;
        cause_d  = CAUSE_MGR;
        if (press)
        begin
            policy_d = !policy_q;
            cause_d  = CAUSE_BUTTON;
            unique case (state_q)
                ST_ACTIVE:   state_d = ST_DEA_REQ;
                ST_INACTIVE: state_d = ST_ACT_REQ;
                ST_ACT_REQ:  state_d = ST_INACTIVE;
                ST_DEA_REQ:  state_d = ST_ACTIVE;
                ST_ACT_PROG,
                ST_DEA_PROG: state_d = state_q;
            endcase
        end
        else if (cm_advance)
        begin
            unique case (state_q)
                ST_ACT_REQ:  state_d = ST_ACT_PROG;
                ST_ACT_PROG: state_d = ST_ACTIVE;
                ST_DEA_REQ:  state_d = ST_DEA_PROG;
                ST_DEA_PROG: state_d = ST_INACTIVE;
                ST_INACTIVE,
                ST_ACTIVE:   state_d = state_q;
            endcase
        end
        else if (cm_abort)
        begin
            unique case (state_q)
                ST_ACT_REQ:  state_d = ST_INACTIVE;
                ST_DEA_REQ:  state_d = ST_ACTIVE;
                ST_INACTIVE, ST_ACT_PROG,
                ST_ACTIVE,   ST_DEA_PROG: state_d = state_q;
            endcase
        end
    end

    assign state_chg = (state_d != state_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q  <= ST_INACTIVE;
            policy_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            policy_q <= policy_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_q <= '0;
        else if (state_chg)
            event_q <= '{cause: cause_d, prev: 6'(state_q),
                         curr: 6'(state_d)};
    end

    // ----------------------------------------------------------------
    // Identify and fault aggregation
    // ----------------------------------------------------------------
    // Timed identify restarts on each write that sets ident_on; on
    // expiry only the display drops, the request bit stays set.
    assign ident_exp = ident_q && !ctrl_q.ident_force &&
                       (ident_cnt_q == 32'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ident_q     <= 1'b0;
            ident_cnt_q <= 32'h0;
        end
        else if (wr_acc && (paddr == ADDR_CTRL) && pwdata[1])
        begin
            ident_q     <= 1'b1;
            ident_cnt_q <= 32'(IDENT_CYC - 1);
        end
        else if (ctrl_q.ident_force)
            ident_q <= 1'b1;
        else if (!ctrl_q.ident_on || ident_exp)
            ident_q <= 1'b0;
        else if (ident_cnt_q != 32'h0)
            ident_cnt_q <= ident_cnt_q - 32'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fsync1_q <= '0;
            fsync2_q <= '0;
        end
        else
        begin
            fsync1_q <= fault_in;
            fsync2_q <= fsync1_q;
        end
    end

    assign fault_any = |(fsync2_q & fmask_q);

    // ----------------------------------------------------------------
    // LED patterns
    // ----------------------------------------------------------------
    fpl_blink #(
        .PERIOD_CYC (SLOW_CYC),
        .ON_CYC     (SLOW_CYC / 2)
    ) u_slow (
        .pclk    (pclk),
        .presetn (presetn),
        .blink   (slow_blink)
    );

    fpl_blink #(
        .PERIOD_CYC (SPACED_CYC),
        .ON_CYC     (SPACED_ON)
    ) u_spaced (
        .pclk    (pclk),
        .presetn (presetn),
        .blink   (spaced_blink)
    );

    fpl_blink #(
        .PERIOD_CYC (IDENT_BLINK),
        .ON_CYC     (IDENT_BLINK / 2)
    ) u_ident (
        .pclk    (pclk),
        .presetn (presetn),
        .blink   (ident_blink)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            power_led <= 1'b0;
        else
        begin
            unique case (state_q)
                ST_INACTIVE: power_led <= 1'b0;
                ST_ACTIVE:   power_led <= ctrl_q.activity ? 1'b1
                                                          : spaced_blink;
                ST_ACT_REQ, ST_ACT_PROG,
                ST_DEA_REQ, ST_DEA_PROG: power_led <= slow_blink;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_led <= 1'b0;
        else if (ident_q)
            fault_led <= ident_blink;
        else
            fault_led <= fault_any;
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign int_set = {ident_exp, press, state_chg};

    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat_q <= '0;
        else
            int_stat_q <= (int_stat_q & ~int_clr) | int_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(int_stat_q & int_en_q);
    end

endmodule
`default_nettype wire

// *** hdl/fpl_pkg.sv ***
// Purpose: Constants, register map and types of the face plate LED and
//          request button controller.
// Assumes: pclk at 10 MHz, APB register access with 32-bit data.
// Notes:   Long timing counts become top-level parameters.
//
// Summary of operation
// - Power LED off when inactive, slow blink in transit, else spaced or on.
// - Identify, forced or timed, overrides the fault display.
// - Identify off or expired restores the aggregated fault display.
// - A press never drives power; it only requests a state change.
// - Each accepted press inverts the activation policy variable.
// - Active press sets policy deactivate, enters deactivation requested; the code inverts the policy bit instead.
// - Inactive press enters activation requested; a second press goes back.
// - Press-caused state change event carries cause code three.
// - Software enable bit can disable the request button.
// - Fault LED shows the OR of masked fault inputs.
package fpl_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ            = 10_000_000;
    localparam int CYC_PER_MS        = CLK_HZ / 1000;
    localparam int SLOW_PERIOD_CYC   = 1000 * CYC_PER_MS;
    localparam int SPACED_PERIOD_CYC = 2000 * CYC_PER_MS;
    localparam int SPACED_ON_CYC     = 100 * CYC_PER_MS;
    localparam int IDENT_PERIOD_CYC  = 250 * CYC_PER_MS;
    localparam int IDENT_DUR_CYC     = 15000 * CYC_PER_MS;
    localparam int DEBOUNCE_CYC      = 20 * CYC_PER_MS;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CMD      = 8'h04;
    localparam logic [7:0] ADDR_FMASK    = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_EVENT    = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_CLR  = 8'h18;
    localparam logic [7:0] ADDR_INT_EN   = 8'h1c;

    localparam int NUM_FAULTS = 8;
    localparam int NUM_INTS   = 3;
    localparam logic [3:0] CAUSE_BUTTON = 4'h3;
    localparam logic [3:0] CAUSE_MGR    = 4'h1;
    localparam logic [NUM_FAULTS-1:0] FMASK_RST = 8'hff;

    // CTRL register fields.
    typedef struct packed {
        logic activity;
        logic ident_force;
        logic ident_on;
        logic btn_en;
    } fpl_ctrl_t;
    localparam fpl_ctrl_t CTRL_RST = 4'h1;

    // CMD bits, write-only.
    localparam int CMD_ADVANCE = 0;
    localparam int CMD_ABORT   = 1;

    typedef enum logic [5:0] {
        ST_INACTIVE = 6'b000001,
        ST_ACT_REQ  = 6'b000010,
        ST_ACT_PROG = 6'b000100,
        ST_ACTIVE   = 6'b001000,
        ST_DEA_REQ  = 6'b010000,
        ST_DEA_PROG = 6'b100000
    } fpl_state_t;

    // Operational state change event record.
    typedef struct packed {
        logic [3:0] cause;
        logic [5:0] prev;
        logic [5:0] curr;
    } fpl_event_t;

endpackage

// *** hdl/fpl_blink.sv ***
// Purpose: Free-running blink pattern generator.
// Assumes: ON_CYC not above PERIOD_CYC.
// Notes:   Output is high for the first ON_CYC cycles of each period.
`timescale 1ns/1ps
`default_nettype none
module fpl_blink #(
    parameter int PERIOD_CYC = 16,
    parameter int ON_CYC     = 8
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output var  logic blink
);
    logic [31:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 32'h0;
        else if (cnt_q >= 32'(PERIOD_CYC - 1))
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_q + 32'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blink <= 1'b0;
        else
            blink <= (cnt_q < 32'(ON_CYC));
    end
endmodule
`default_nettype wire

// *** hdl/fpl_debounce.sv ***
// Purpose: Synchronise and debounce the active-low request button.
// Assumes: Button pin is asynchronous to pclk.
// Notes:   Emits one pulse per debounced press, on the press edge.
`timescale 1ns/1ps
`default_nettype none
module fpl_debounce #(
    parameter int STABLE_CYC = 4
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic button_n,
    output var  logic press
);
    logic        sync1_q;
    logic        sync2_q;
    logic        level_q;
    logic [31:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= ~button_n;
            sync2_q <= sync1_q;
        end
    end

    // A level must hold for STABLE_CYC cycles before it is believed.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q   <= 32'h0;
            level_q <= 1'b0;
            press   <= 1'b0;
        end
        else
        begin
            press <= 1'b0;
            if (sync2_q == level_q)
                cnt_q <= 32'h0;
            else if (cnt_q >= 32'(STABLE_CYC - 1))
            begin
                cnt_q   <= 32'h0;
                level_q <= sync2_q;
                press   <= sync2_q;
            end
            else
                cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule
`default_nettype wire

// *** dv/fpl_operator.sv ***
// Purpose: Operator model that works the face plate request button.
// Assumes: The button line has a pull-up, so it rests high when let go.
// Notes:   Each push starts with contact bounce shorter than debounce.
`timescale 1ns/1ps
`default_nettype none
module fpl_operator (
    input  wire logic pclk,
    output var  logic button_n
);
    initial button_n = 1'b1;

    // ----------------------------------------------------------------
    // Push with bounce
    // ----------------------------------------------------------------
    // A bounce taken as a press would toggle the policy twice.
    task automatic push(input int hold);
        button_n <= 1'b0;
        repeat (2) @(posedge pclk);
        button_n <= 1'b1;
        @(posedge pclk);
        button_n <= 1'b0;
        repeat (hold) @(posedge pclk);
        button_n <= 1'b1;
        repeat (hold) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// *** dv/fpl_ctrl_sva.sv ***
// Purpose: Port-level assertions for the face plate controller.
// Assumes: CTRL and FMASK are shadowed from completed APB writes.
// Notes:   Fault checks wait until the inputs sit still for 7 cycles.
`timescale 1ns/1ps
`default_nettype none
module fpl_ctrl_sva
    import fpl_pkg::*;
#(
    parameter int IDENT_BLINK = 8
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  button_n,
    input wire logic [NUM_FAULTS-1:0] fault_in,
    input wire logic                  power_led,
    input wire logic                  fault_led,
    input wire logic                  irq
);
    localparam int IB2 = 2 * IDENT_BLINK;
    logic       wr;
    logic [3:0] ctrl_q;
    logic [7:0] fmask_q;
    logic       pushed_q;
    logic [2:0] calm_q;

    assign wr = psel && penable && pready && pwrite;

    // ----------------------------------------------------------------
    // Shadow state
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= 4'h1;
            fmask_q  <= FMASK_RST;
            pushed_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == ADDR_CTRL)
                ctrl_q <= pwdata[3:0];
            if (wr && paddr == ADDR_FMASK)
                fmask_q <= pwdata[7:0];
            if (!button_n)
                pushed_q <= 1'b1;
        end
    end

    // Any write may move the fault display, so it restarts the wait too.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            calm_q <= 3'h0;
        else if ($changed(fault_in) || wr)
            calm_q <= 3'h0;
        else if (calm_q != 3'h7)
            calm_q <= calm_q + 3'h1;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_lit;
        ##[0:IB2] fault_led;
    endsequence
    sequence s_dark;
        ##[1:IB2] !fault_led;
    endsequence

    ready_after_setup_a: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    unmapped_err_a: assert property (pready && paddr > ADDR_INT_EN |-> pslverr)
        else $error("unmapped access without pslverr");
    mapped_ok_a: assert property (pready && paddr <= ADDR_INT_EN
        && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("pslverr on mapped register");
    err_data_a: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0)
        else $error("refused read returned data");
    ctrl_read_a: assert property (pready && !pwrite && paddr == ADDR_CTRL
        |-> (prdata[3:0] & 4'hd) == (ctrl_q & 4'hd))
        else $error("control readback differs");
    fmask_read_a: assert property (pready && !pwrite
        && paddr == ADDR_FMASK |-> prdata[7:0] == fmask_q)
        else $error("fault mask readback differs");
    idle_led_a: assert property (!pushed_q |-> !power_led && !irq)
        else $error("power led or irq set while inactive");
    fault_show_a: assert property (calm_q == 3'h7
        && ctrl_q[2:1] == 2'b00 |-> fault_led == |(fault_in & fmask_q))
        else $error("fault led differs from fault sum");
    ident_blink_a: assert property (calm_q == 3'h7 && ctrl_q[2]
        |-> s_lit ##0 s_dark)
        else $error("forced identify not shown");
endmodule

bind fpl_ctrl fpl_ctrl_sva #(
    .IDENT_BLINK(IDENT_BLINK)
) fpl_ctrl_sva_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .button_n, .fault_in, .power_led,
    .fault_led, .irq
);
`default_nettype wire

// *** dv/faceplate_led_button_control_tb_top.sv ***
// Purpose: Self-checking bench for the face plate controller.
// Assumes: Shortened blink, identify and debounce counts.
// Notes:   Reads note their expected word; a monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module faceplate_led_button_control_tb_top;
    import fpl_pkg::*;
    localparam int ID_CYC = 100;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h0;
    logic [31:0] pwdata   = 32'h0;
    logic [7:0]  fault_in = 8'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        button_n;
    logic        power_led;
    logic        fault_led;
    logic        irq;
    logic [7:0]  m, f;
    logic [32:0] exp_q[$];
    int          n_fail = 0;
    int          checks = 0;
    int          k;

    always #50 pclk = ~pclk;

    fpl_ctrl #(
        .SLOW_CYC(16), .SPACED_CYC(32),
        .IDENT_BLINK(8), .IDENT_CYC(ID_CYC), .DEBOUNCE_CYCLES(4)
    ) fpl_ctrl_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .button_n, .fault_in, .power_led,
        .fault_led, .irq
    );
    fpl_operator fpl_operator_inst (.pclk, .button_n);

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t pin %b expected %b", $time, got, exp);
        end
    endtask

    // Called just after a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] x);
        int n;
        if (!w)
            exp_q.push_back(x);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            chk_pin(1'b0, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask

    task automatic press;
        fpl_operator_inst.push(12);
        k = 0;
        while (irq !== 1'b1 && k < 40)
        begin
            @(posedge pclk);
            k++;
        end
    endtask

    task automatic lit(input int n, input int x);
        k = 0;
        repeat (4) @(posedge pclk);
        repeat (n)
        begin
            @(posedge pclk);
            k += int'(power_led === 1'b1);
        end
        chk(33'(k), 33'(x));
    endtask

    function automatic logic [31:0] st(logic p, fpl_state_t s);
        return {25'h0, p, s};
    endfunction

    function automatic logic [31:0] ev(logic [3:0] c, fpl_state_t p,
                                       fpl_state_t s);
        return {16'h0, c, p, s};
    endfunction

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            chk({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h0);
        end
    end

    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        results();
    end

    initial
    begin
        void'($urandom(32'h5fc8));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, 32'h1);
        rd(ADDR_FMASK, 32'hff);
        rd(ADDR_STATUS, st(1'b0, ST_INACTIVE));
        rd(ADDR_INT_STAT, 32'h0);
        rd(ADDR_INT_EN, 32'h0);
        apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
        wr(ADDR_INT_EN, 32'h7);
        lit(32, 0);
        press();
        rd(ADDR_STATUS, st(1'b1, ST_ACT_REQ));
        rd(ADDR_EVENT, ev(CAUSE_BUTTON, ST_INACTIVE, ST_ACT_REQ));
        rd(ADDR_INT_STAT, 32'h3);
        lit(32, 16);
        wr(ADDR_INT_CLR, 32'h3);
        repeat (2) @(posedge pclk);
        chk_pin(irq, 1'b0);
        press();
        rd(ADDR_STATUS, st(1'b0, ST_INACTIVE));
        rd(ADDR_EVENT, ev(CAUSE_BUTTON, ST_ACT_REQ, ST_INACTIVE));
        wr(ADDR_INT_CLR, 32'h3);
        press();
        wr(ADDR_CMD, 32'h1);
        wr(ADDR_CMD, 32'h1);
        rd(ADDR_STATUS, st(1'b1, ST_ACTIVE));
        rd(ADDR_EVENT, ev(CAUSE_MGR, ST_ACT_PROG, ST_ACTIVE));
        lit(64, 2);
        wr(ADDR_CTRL, 32'h9);
        lit(40, 40);
        wr(ADDR_INT_CLR, 32'h7);
        press();
        rd(ADDR_STATUS, st(1'b0, ST_DEA_REQ));
        rd(ADDR_EVENT, ev(CAUSE_BUTTON, ST_ACTIVE, ST_DEA_REQ));
        lit(32, 16);
        wr(ADDR_INT_CLR, 32'h7);
        wr(ADDR_CTRL, 32'h8);
        press();
        chk_pin(irq, 1'b0);
        rd(ADDR_STATUS, st(1'b0, ST_DEA_REQ));
        rd(ADDR_INT_STAT, 32'h0);
        wr(ADDR_CMD, 32'h2);
        rd(ADDR_STATUS, st(1'b0, ST_ACTIVE));
        wr(ADDR_CTRL, 32'h1);
        repeat (4)
        begin
            m = 8'($urandom);
            f = 8'($urandom);
            wr(ADDR_FMASK, {24'h0, m});
            fault_in <= f;
            repeat (8) @(posedge pclk);
            chk_pin(fault_led, |(f & m));
        end
        fault_in <= 8'hff;
        wr(ADDR_FMASK, 32'hff);
        wr(ADDR_CTRL, 32'h5);
        repeat (8) @(posedge pclk);
        k = 0;
        while (fault_led !== 1'b0 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        chk_pin(k < 20, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        repeat (8) @(posedge pclk);
        chk_pin(fault_led, 1'b1);
        wr(ADDR_INT_CLR, 32'h7);
        wr(ADDR_CTRL, 32'h3);
        repeat (ID_CYC + 10) @(posedge pclk);
        chk_pin(fault_led, 1'b1);
        chk_pin(irq, 1'b1);
        rd(ADDR_INT_STAT, 32'h4);
        results();
    end
endmodule
`default_nettype wire
